// ### rtl/bgd_gate_ctrl.sv
// Gate drive control for a synchronous buck power stage
`timescale 1ns/1ps
`default_nettype none
module bgd_gate_ctrl
    import bgd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Controller inputs
    input wire logic pwm,
    input wire logic pwm_mid,
    input wire logic rectifier_enable,
    input wire logic rectifier_enable_driven,
    input wire logic rectifier_mode_select,
    // Fault sources
    input wire bgd_faults_t faults,
    // Gate state feedback (gate to source voltage above off level)
    input wire logic high_side_fb,
    input wire logic low_side_fb,
    // Outputs
    output bgd_gates_t gates,
    output logic fault_flag,
    output logic tristate_active,
    output logic sync_mode
);
    typedef enum logic [1:0] {ST_OFF, ST_HIGH, ST_DEAD, ST_LOW} bgd_state_t;

    bgd_state_t state_ff, nxt_state;
    bgd_gates_t gates_ff, nxt_gates;
    logic [BGD_DEAD_W-1:0] dead_ff, nxt_dead;
    logic fault_ff;
    logic tristate;
    logic sre_eff;
    logic any_fault;
    logic want_high;
    logic want_low;

    // Both gates must read off; used by every handover in synchronous mode
    function automatic logic both_off(input logic hs, input logic ls);
        both_off = !hs && !ls;
    endfunction

    bgd_tristate_det u_tri (
        .clk(clk),
        .rst_b(rst_b),
        .pwm_mid(pwm_mid),
        .tristate(tristate)
    );

    // Floating enable pin is pulled up
    assign sre_eff = rectifier_enable || !rectifier_enable_driven;
    // Any fault source is an immediate kill, no waiting for the controller
    assign any_fault = |faults;
    assign want_high = pwm;
    assign want_low = !pwm && sre_eff;

    // Synchronous sequencer with interlock; dead state waits for feedback and count
    always_comb begin
        nxt_state = state_ff;
        nxt_dead = dead_ff;
        if (any_fault || tristate || !rectifier_mode_select) begin
            nxt_state = ST_OFF;
            nxt_dead = '0;
        end else begin
            unique case (state_ff)
                ST_OFF: begin
                    if (want_high || want_low) begin
                        nxt_state = ST_DEAD;
                        nxt_dead = '0;
                    end
                end
                ST_HIGH: begin
                    if (!want_high) begin
                        nxt_state = ST_DEAD;
                        nxt_dead = '0;
                    end
                end
                ST_LOW: begin
                    if (!want_low) begin
                        nxt_state = ST_DEAD;
                        nxt_dead = '0;
                    end
                end
                ST_DEAD: begin
                    // Outgoing FET must read off before the other is allowed on
                    if (!both_off(high_side_fb, low_side_fb)) begin
                        nxt_dead = '0;
                    end else if (dead_ff < BGD_DEAD_W'(BGD_DEAD_CYC)) begin
                        nxt_dead = dead_ff + BGD_DEAD_W'(1);
                    end else if (want_high) begin
                        nxt_state = ST_HIGH;
                    end else if (want_low) begin
                        nxt_state = ST_LOW;
                    end else begin
                        nxt_state = ST_OFF;
                    end
                end
            endcase
        end
    end

    // Gate command selection per mode
    always_comb begin
        nxt_gates = '{high_side_gate: BGD_GATE_RST, low_side_gate: BGD_GATE_RST};
        if (any_fault || tristate) begin
            nxt_gates = '{high_side_gate: 1'h0, low_side_gate: 1'h0};
        end else if (rectifier_mode_select) begin
            nxt_gates.high_side_gate = (nxt_state == ST_HIGH) && pwm;
            nxt_gates.low_side_gate = (nxt_state == ST_LOW) && want_low;
        end else begin
            // No interlock here; overlap avoidance is the controller's job
            nxt_gates.high_side_gate = pwm;
            nxt_gates.low_side_gate = sre_eff;
        end
    end

    // Sequencer state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_OFF;
            dead_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            dead_ff <= nxt_dead;
        end
    end

    // Registered gate commands, off from reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gates_ff <= '{high_side_gate: BGD_GATE_RST, low_side_gate: BGD_GATE_RST};
        end else begin
            gates_ff <= nxt_gates;
        end
    end

    // Fault flag: high in reset since supply state is unknown
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_ff <= BGD_FAULT_RST;
        end else begin
            fault_ff <= any_fault;
        end
    end

    assign gates = gates_ff;
    assign fault_flag = fault_ff;
    assign tristate_active = tristate;
    assign sync_mode = rectifier_mode_select;
endmodule // bgd_gate_ctrl
`default_nettype wire

// ### rtl/bgd_pkg.sv
// Package for the buck gate drive control block: constants and carrier types
package bgd_pkg;

    // Tri-state hold-off time in ns and derived count at 10 MHz (least time, rounded up)
    localparam int BGD_CLK_PERIOD_NS = 100;
    localparam int BGD_HOLDOFF_NS = 300;
    localparam int BGD_HOLDOFF_CYC_RAW =
        (BGD_HOLDOFF_NS + BGD_CLK_PERIOD_NS - 1) / BGD_CLK_PERIOD_NS;
    localparam int BGD_HOLDOFF_CYC = (BGD_HOLDOFF_CYC_RAW < 1) ? 1 : BGD_HOLDOFF_CYC_RAW;
    localparam int BGD_HOLDOFF_W = 8;

    // Interlock confirm: cycles the outgoing gate must read off before the other turns on
    localparam int BGD_DEAD_NS = 100;
    localparam int BGD_DEAD_CYC_RAW = (BGD_DEAD_NS + BGD_CLK_PERIOD_NS - 1) / BGD_CLK_PERIOD_NS;
    localparam int BGD_DEAD_CYC = (BGD_DEAD_CYC_RAW < 1) ? 1 : BGD_DEAD_CYC_RAW;
    localparam int BGD_DEAD_W = 4;

    // Reset values of the gate commands and fault flag
    localparam logic BGD_GATE_RST = 1'h0;
    localparam logic BGD_FAULT_RST = 1'h1;

    // Gate command pair
    typedef struct packed {
        logic high_side_gate;
        logic low_side_gate;
    } bgd_gates_t;

    // Fault sources
    typedef struct packed {
        logic supply_lockout;
        logic high_side_oc;
        logic output_oc;
        logic thermal;
    } bgd_faults_t;

endpackage

// ### rtl/bgd_tristate_det.sv
// Tri-state persistence detector for the pwm input
`timescale 1ns/1ps
`default_nettype none
module bgd_tristate_det
    import bgd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Mid-level indication and result
    input wire logic pwm_mid,
    output logic tristate
);
    logic [BGD_HOLDOFF_W-1:0] cnt_ff;
    logic tristate_ff;

    // Count mid-level cycles; any valid level restarts the count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= '0;
        end else if (!pwm_mid) begin
            cnt_ff <= '0;
        end else if (cnt_ff != BGD_HOLDOFF_W'(BGD_HOLDOFF_CYC)) begin
            cnt_ff <= cnt_ff + BGD_HOLDOFF_W'(1);
        end
    end

    // Tri-state held only while the mid level persists past hold-off
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tristate_ff <= 1'h0;
        end else begin
            tristate_ff <= pwm_mid && (cnt_ff == BGD_HOLDOFF_W'(BGD_HOLDOFF_CYC));
        end
    end

    assign tristate = tristate_ff;
endmodule // bgd_tristate_det
`default_nettype wire

// ### testbench/bgd_checker.sv
// Assertion checker for the gate drive control block
`timescale 1ns/1ps
`default_nettype none
module bgd_checker
    import bgd_pkg::*;
(
    // Clock, reset, controller inputs
    input wire logic clk, rst_b, pwm, pwm_mid, rectifier_enable,
    input wire logic rectifier_enable_driven, rectifier_mode_select,
    input wire bgd_faults_t faults,
    // Outputs under watch
    input wire bgd_gates_t gates,
    input wire logic fault_flag, tristate_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Quiet states; a floating enable reads high
    wire logic ok = faults == 4'h0 && !tristate_active;
    wire logic ind = !rectifier_mode_select && ok;
    wire logic syn = rectifier_mode_select && ok && !pwm_mid;
    wire logic en = rectifier_enable || !rectifier_enable_driven;
    no_overlap_a: assert property (rectifier_mode_select |-> gates != 2'b11)
        else $error("gates overlap");
    lockout_off_a: assert property (faults.supply_lockout
        |=> fault_flag && gates == 2'b00) else $error("pulse in lockout");
    fault_cut_a: assert property (faults != 4'h0 |=> fault_flag && gates == 2'b00)
        else $error("fault ignored");
    ind_high_a: assert property (ind |=> gates.high_side_gate == $past(pwm))
        else $error("high side wrong");
    ind_low_a: assert property (ind |=> gates.low_side_gate == $past(en))
        else $error("low side wrong");
    sync_ls_off_a: assert property (rectifier_mode_select && (pwm || !en)
        |=> !gates.low_side_gate) else $error("low side barred");
    sync_hs_on_a: assert property ((syn && pwm)[*8] |-> gates.high_side_gate)
        else $error("high side late");
    sync_ls_on_a: assert property ((syn && !pwm && en)[*8] |-> gates.low_side_gate)
        else $error("low side late");
    tri_off_a: assert property (pwm_mid[*7] |-> tristate_active && gates == 2'b00)
        else $error("tri-state ignored");
    // Main scenarios reached
    cover property (tristate_active);
    cover property (ind && en);
    cover property (syn && gates.high_side_gate);
endmodule // bgd_checker
bind bgd_gate_ctrl bgd_checker chk(.*);
`default_nettype wire

// ### testbench/bgd_ctl_model.sv
// Controller model driving the stage's control inputs
`timescale 1ns/1ps
`default_nettype none
module bgd_ctl_model (
    // Clock
    input wire logic clk,
    // Control lines
    output logic pwm, pwm_mid, rectifier_enable, rectifier_enable_driven, rectifier_mode_select
);
    // Mode changes only while the stage is held in reset
    task automatic set_mode(input logic m);
        @(posedge clk);
        rectifier_mode_select <= m;
    endtask
    // One step; tri-state is left by parking pwm low first, so the bootstrap recharges
    task automatic step(input logic p, mid, en, drv);
        if (pwm_mid && !mid) begin
            @(posedge clk);
            {pwm, pwm_mid} <= 2'h0;
        end
        @(posedge clk);
        {pwm, pwm_mid, rectifier_enable_driven} <= {p, mid, drv};
        rectifier_enable <= en && !(p && !rectifier_mode_select);
    endtask
    initial {pwm, pwm_mid, rectifier_enable, rectifier_enable_driven, rectifier_mode_select} = 5'h3;
endmodule // bgd_ctl_model
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking testbench for the gate drive control block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bgd_pkg::*;
;
    logic clk, rst_b, high_side_fb, low_side_fb, fault_flag, tristate_active, sync_mode;
    logic pwm, pwm_mid, rectifier_enable, rectifier_enable_driven, rectifier_mode_select;
    bgd_faults_t faults;
    bgd_gates_t gates;
    int n_errors, comparisons;
    logic [4:0] tbl [4] = '{5'h16, 5'h0d, 5'h04, 5'h01};
    bgd_ctl_model ctl(.*);
    bgd_gate_ctrl dut(.*);
    // Clock; FET feedback lags the gate command by a cycle
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) {high_side_fb, low_side_fb} <= gates;
    task automatic chk(input logic [3:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Step, wait, compare gates, flag and tri-state
    task automatic run(input logic p, mid, en, drv, input int n, input logic [3:0] exp);
        ctl.step(p, mid, en, drv);
        repeat (n) @(posedge clk);
        #1;
        chk({gates, fault_flag, tristate_active}, exp);
    endtask
    task automatic conclude;
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial begin
        #100000;
        n_errors++;
        conclude;
    end
    initial begin
        {n_errors, comparisons} = 0;
        {rst_b, high_side_fb, low_side_fb} = 3'h0;
        faults = 4'h8;
        repeat (5) @(posedge clk);
        #1;
        chk({gates, fault_flag, tristate_active}, 4'h2);
        rst_b <= 1'h1;
        run(1, 0, 1, 1, 10, 4'h2);
        faults <= 4'h0;
        run(1, 0, 1, 1, 10, 4'h8);
        chk({3'h0, sync_mode}, 4'h1);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            faults <= 4'h1 << i;
            run(1, 0, 1, 1, 0, 4'h2);
            faults <= 4'h0;
            run(1, 0, 1, 1, 10, 4'h8);
        end
        run(0, 0, 1, 1, 10, 4'h4);
        run(0, 0, 0, 1, 3, 4'h0);
        run(0, 0, 0, 0, 10, 4'h4);
        for (int i = 0; i < 8; i++) ctl.step(i[0], 0, 1, 1);
        run(1, 1, 1, 1, 7, 4'h1);
        run(0, 0, 1, 1, 10, 4'h4);
        // Independent mode entered under reset
        rst_b <= 1'h0;
        ctl.set_mode(0);
        @(posedge clk);
        rst_b <= 1'h1;
        foreach (tbl[i]) begin
            run(tbl[i][4], 0, tbl[i][3], tbl[i][2], 1, {tbl[i][1:0], 2'h0});
        end
        chk({3'h0, sync_mode}, 4'h0);
        run(0, 1, 1, 1, 7, 4'h1);
        conclude;
    end
endmodule // testbench
`default_nettype wire
